// ---- pkg/pwmc_defs.svh ----
// Register offsets, field positions, reset values, channel count and counter width
`ifndef PWMC_DEFS_SVH
`define PWMC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets and channel register word indices
// ---------------------------------------------------------------
`define PWMC_OFS_IRQ_ENABLE  8'h10
`define PWMC_OFS_IRQ_DISABLE 8'h14
`define PWMC_OFS_IRQ_MASK    8'h18
`define PWMC_OFS_IRQ_STATUS  8'h1C
`define PWMC_OFS_CH_BASE     8'h80
`define PWMC_CH_STRIDE_LOG2  5
`define PWMC_OFS_CH_MODE     3'h0
`define PWMC_OFS_CH_DUTY     3'h1
`define PWMC_OFS_CH_PERIOD   3'h2
`define PWMC_OFS_CH_COUNTER  3'h3
`define PWMC_OFS_CH_UPDATE   3'h4

// ---------------------------------------------------------------
// Channel mode field positions
// ---------------------------------------------------------------
`define PWMC_MODE_PRE_LSB    0
`define PWMC_MODE_ALIGN_BIT  8
`define PWMC_MODE_POL_BIT    9
`define PWMC_MODE_UPD_BIT    10

// ---------------------------------------------------------------
// Prescaler codes and reset values
// ---------------------------------------------------------------
`define PWMC_PRE_MAX_POW     4'hA
`define PWMC_PRE_CLK_A       4'hB
`define PWMC_PRE_CLK_B       4'hC
`define PWMC_RST_WORD        16'h0000
`define PWMC_NUM_CH          4
`define PWMC_CNT_W           16

`endif

// ---- pkg/pwmc_pkg.sv ----
// Types shared by the channel logic and the register file
package pwmc_pkg;

  // Per-channel mode settings
  typedef struct packed {
    logic       upd_period;   // Update target: 0 duty, 1 period
    logic       pol_high;     // Start level
    logic       center;       // Alignment
    logic [3:0] pre_sel;      // Counter clock source
  } pwmc_mode_t;

  // Channel counter direction state, one-hot
  typedef enum logic [1:0] {
    PWMC_UP   = 2'b01,
    PWMC_DOWN = 2'b10
  } pwmc_dir_t;

endpackage

// ---- src/pwmc_prescale.sv ----
// Master-clock prescaler giving power-of-two tick enables
`timescale 1ns/1ps
`include "pwmc_defs.svh"

module pwmc_prescale
(
  input  wire logic        clk,    // Master clock
  input  wire logic        rst,    // Synchronous reset
  output logic      [10:0] tick    // tick[k]: one pulse per 2**k cycles
);

  // ---------------------------------------------------------------
  // Free-running divide counter
  // ---------------------------------------------------------------
  logic [9:0] div_r;  // Ripple count

  always_ff @(posedge clk)
  begin
    if (rst)
      div_r <= 10'h000;
    else
      div_r <= div_r + 10'h001;
  end

  // Tick k fires when the low k bits are all ones
  genvar k;
  generate
    for (k = 0; k < 11; k++)
    begin : g_tick
      if (k == 0)
      begin : g_zero
        assign tick[k] = 1'b1;
      end
      else
      begin : g_pow
        assign tick[k] = &div_r[k-1:0];
      end
    end
  endgenerate

endmodule

// ---- src/pwmc_channel.sv ----
// One channel: counter, waveform and period-end pulse
`timescale 1ns/1ps
`include "pwmc_defs.svh"

module pwmc_channel
(
  input  wire logic                     clk,        // Master clock
  input  wire logic                     rst,        // Synchronous reset
  input  wire logic                     enable,     // Channel running
  input  wire logic                     start,      // Enable pulse
  input  wire logic                     cnt_tick,   // Counter clock enable
  input  wire pwmc_pkg::pwmc_mode_t     mode,       // Channel mode
  input  wire logic [15:0]              duty_in,    // Duty register
  input  wire logic [15:0]              period_in,  // Period register
  output logic      [15:0]              counter,    // Counter value
  output logic                          wave,       // Output level
  output logic                          period_end  // Period done pulse
);

  // ---------------------------------------------------------------
  // Counter and direction
  // ---------------------------------------------------------------
  pwmc_pkg::pwmc_dir_t dir_r;   // Count direction
  logic                at_top;  // Counter reached period
  logic                at_bot;  // Counter at one or zero
  logic                at_wrap; // Left count on its last step

  assign at_top = (counter >= period_in);
  assign at_bot = (counter == 16'h0001) || (counter == 16'h0000);
  // Left count shows 0..period-1, so one period is exactly period ticks
  assign at_wrap = (({1'b0, counter} + 17'h0_0001) >= {1'b0, period_in});

  // Period end: left wrap or end of down count
  assign period_end = enable && cnt_tick &&
                      (mode.center ? (dir_r == pwmc_pkg::PWMC_DOWN && at_bot)
                                   : at_wrap);

  // Counter walks on each tick
  always_ff @(posedge clk)
  begin
    if (rst || start)
    begin
      counter <= 16'h0000;
      dir_r   <= pwmc_pkg::PWMC_UP;
    end
    else if (enable && cnt_tick)
    begin
      case (dir_r)
        pwmc_pkg::PWMC_UP:
        begin
          if (at_top && mode.center)
          begin
            counter <= counter - 16'h0001;
            dir_r   <= pwmc_pkg::PWMC_DOWN;
          end
          else if (!mode.center && at_wrap)
            counter <= 16'h0000;
          else
            counter <= counter + 16'h0001;
        end
        pwmc_pkg::PWMC_DOWN:
        begin
          if (at_bot)
          begin
            counter <= 16'h0000;
            dir_r   <= pwmc_pkg::PWMC_UP;
          end
          else
            counter <= counter - 16'h0001;
        end
        default:
          dir_r <= pwmc_pkg::PWMC_UP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Waveform: start level until counter meets duty
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      wave <= mode.pol_high;
    else if (counter >= duty_in && !(dir_r == pwmc_pkg::PWMC_DOWN))
      wave <= ~mode.pol_high;
    else if (dir_r == pwmc_pkg::PWMC_DOWN && counter < duty_in)
      wave <= mode.pol_high;
    else if (counter < duty_in)
      wave <= mode.pol_high;
  end

endmodule

// ---- src/pwmc_top.sv ----
// Four-channel pulse-width modulator registers, counters and interrupt
//
// Summary of operation
// - Writing one disables that channel interrupt
// - Status flag set after completed period
// - Reading status clears returned flags
// - Codes 0-10 divide master clock by 2**n
// - Codes 11,12 pick divided clocks A, B
// - Bit 8 picks left or center alignment
// - Bit 9 picks the start level
// - Bit 10 routes update to duty or period
// - Only low 16 bits are significant
// - Left period is period times divisor
// - Center period is twice that
// - Counter clears when channel is enabled
// - Left mode clears counter at period
// - Counter register reads live counter
// - Update buffered until next period start
`timescale 1ns/1ps
`include "pwmc_defs.svh"

module pwmc_top
(
  input  wire logic        CLK_SYS,       // 40 MHz master clock
  input  wire logic        RST,           // Synchronous reset, high
  input  wire logic [7:0]  ADDR,          // Byte address
  input  wire logic [31:0] WDATA,         // Write data
  input  wire logic        WR,            // Write strobe
  input  wire logic        RD,            // Read strobe
  output logic      [31:0] RDATA,         // Read data, cycle after RD
  input  wire logic [3:0]  CH_ENABLE,     // Channel enabled levels
  input  wire logic [3:0]  CH_START,      // Enable write pulses
  input  wire logic        CLK_A_TICK,    // Divided clock A enable
  input  wire logic        CLK_B_TICK,    // Divided clock B enable
  input  wire logic [3:0]  IRQ_EN_SET,    // Interrupt enable pulses
  output logic      [3:0]  PWM_OUT,       // Channel waveforms
  output logic             IRQ            // Level interrupt
);

  // ---------------------------------------------------------------
  // Shared prescaler
  // ---------------------------------------------------------------
  logic [10:0] tick;  // Power-of-two enables

  pwmc_prescale u_pre
  (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (tick)
  );

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  pwmc_pkg::pwmc_mode_t mode_r   [4];  // Channel mode
  logic [15:0]          duty_r   [4];  // Active duty
  logic [15:0]          period_r [4];  // Active period
  logic [15:0]          upd_r    [4];  // Pending update value
  logic [3:0]           upd_pend_r;    // Update waiting
  logic [3:0]           upd_tgt_r;     // Pending target: 1 period
  logic [3:0]           irq_mask_r;    // Enabled interrupts
  logic [3:0]           irq_stat_r;    // Sticky period flags
  logic [15:0]          counter  [4];  // Live counters
  logic [3:0]           wave;          // Raw waveforms
  logic [3:0]           pend;          // Period-end pulses
  logic [3:0]           cnt_tick;      // Selected counter ticks

  // Address decode
  logic       ch_hit;   // Channel window hit
  logic [1:0] ch_idx;   // Channel number
  logic [2:0] ch_reg;   // Register within channel
  logic       stat_rd;  // Status read this cycle

  assign ch_hit  = (ADDR[7] == 1'b1) && (ADDR[1:0] == 2'b00);
  assign ch_idx  = ADDR[6:5];
  assign ch_reg  = ADDR[4:2];
  assign stat_rd = RD && (ADDR == `PWMC_OFS_IRQ_STATUS);

  // ---------------------------------------------------------------
  // Per-channel clock select, counter and update
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : g_ch
      logic ch_wr;  // Write to this channel

      assign ch_wr = WR && ch_hit && (ch_idx == 2'(c));

      // Counter clock source select
      always_comb
      begin
        case (mode_r[c].pre_sel)
          `PWMC_PRE_CLK_A: cnt_tick[c] = CLK_A_TICK;
          `PWMC_PRE_CLK_B: cnt_tick[c] = CLK_B_TICK;
          default:
          begin
            if (mode_r[c].pre_sel <= `PWMC_PRE_MAX_POW)
              cnt_tick[c] = tick[mode_r[c].pre_sel];
            else
              cnt_tick[c] = 1'b0;  // Reserved code stops counter
          end
        endcase
      end

      // Mode register
      always_ff @(posedge CLK_SYS)
      begin
        if (RST)
          mode_r[c] <= '0;
        else if (ch_wr && ch_reg == `PWMC_OFS_CH_MODE)
        begin
          mode_r[c].pre_sel    <= WDATA[3:0];
          mode_r[c].center     <= WDATA[`PWMC_MODE_ALIGN_BIT];
          mode_r[c].pol_high   <= WDATA[`PWMC_MODE_POL_BIT];
          mode_r[c].upd_period <= WDATA[`PWMC_MODE_UPD_BIT];
        end
      end

      // Duty, period and double-buffered update
      always_ff @(posedge CLK_SYS)
      begin
        if (RST)
        begin
          duty_r[c]     <= `PWMC_RST_WORD;
          period_r[c]   <= `PWMC_RST_WORD;
          upd_r[c]      <= `PWMC_RST_WORD;
          upd_pend_r[c] <= 1'b0;
          upd_tgt_r[c]  <= 1'b0;
        end
        else
        begin
          if (ch_wr && ch_reg == `PWMC_OFS_CH_DUTY)
            duty_r[c] <= WDATA[15:0];
          if (ch_wr && ch_reg == `PWMC_OFS_CH_PERIOD)
            period_r[c] <= WDATA[15:0];
          if (pend[c] && upd_pend_r[c])
          begin
            // Apply at next period start
            if (upd_tgt_r[c])
              period_r[c] <= upd_r[c];
            else
              duty_r[c] <= upd_r[c];
            upd_pend_r[c] <= 1'b0;
          end
          if (ch_wr && ch_reg == `PWMC_OFS_CH_UPDATE)
          begin
            upd_r[c]      <= WDATA[15:0];
            upd_tgt_r[c]  <= mode_r[c].upd_period;
            upd_pend_r[c] <= 1'b1;
          end
        end
      end

      pwmc_channel u_ch
      (
        .clk        (CLK_SYS),
        .rst        (RST),
        .enable     (CH_ENABLE[c]),
        .start      (CH_START[c]),
        .cnt_tick   (cnt_tick[c]),
        .mode       (mode_r[c]),
        .duty_in    (duty_r[c]),
        .period_in  (period_r[c]),
        .counter    (counter[c]),
        .wave       (wave[c]),
        .period_end (pend[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt mask: enable pulses set, disable writes clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      irq_mask_r <= 4'h0;
    else if (WR && ADDR == `PWMC_OFS_IRQ_ENABLE)
      irq_mask_r <= irq_mask_r | WDATA[3:0] | IRQ_EN_SET;
    else if (WR && ADDR == `PWMC_OFS_IRQ_DISABLE)
      irq_mask_r <= (irq_mask_r | IRQ_EN_SET) & ~WDATA[3:0];
    else
      irq_mask_r <= irq_mask_r | IRQ_EN_SET;
  end

  // ---------------------------------------------------------------
  // Sticky status: new events win over read clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      irq_stat_r <= 4'h0;
    else if (stat_rd)
      irq_stat_r <= pend;
    else
      irq_stat_r <= irq_stat_r | pend;
  end

  // ---------------------------------------------------------------
  // Read data, one cycle after strobe
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      RDATA <= 32'h0000_0000;
    else if (RD)
    begin
      RDATA <= 32'h0000_0000;  // Unmapped reads zero
      if (ADDR == `PWMC_OFS_IRQ_MASK)
        RDATA <= {28'h000_0000, irq_mask_r};
      else if (ADDR == `PWMC_OFS_IRQ_STATUS)
        RDATA <= {28'h000_0000, irq_stat_r};
      else if (ch_hit)
      begin
        case (ch_reg)
          `PWMC_OFS_CH_MODE:
            RDATA <= {21'h00_0000, mode_r[ch_idx].upd_period, mode_r[ch_idx].pol_high,
                      mode_r[ch_idx].center, 4'h0, mode_r[ch_idx].pre_sel};
          `PWMC_OFS_CH_DUTY:    RDATA <= {16'h0000, duty_r[ch_idx]};
          `PWMC_OFS_CH_PERIOD:  RDATA <= {16'h0000, period_r[ch_idx]};
          `PWMC_OFS_CH_COUNTER: RDATA <= {16'h0000, counter[ch_idx]};
          default:              RDATA <= 32'h0000_0000;
        endcase
      end
    end
    else
      RDATA <= 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      PWM_OUT <= 4'h0;
      IRQ     <= 1'b0;
    end
    else
    begin
      PWM_OUT <= wave;
      IRQ     <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// ---- testbench/pwmc_monitor.sv ----
// Checker for register reads, mask and counter restart of the modulator
`timescale 1ns/1ps
module pwmc_monitor
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [3:0]  CH_ENABLE,
  input wire logic [3:0]  CH_START,
  input wire logic        CLK_A_TICK,
  input wire logic        CLK_B_TICK,
  input wire logic [3:0]  IRQ_EN_SET,
  input wire logic [3:0]  PWM_OUT,
  input wire logic        IRQ
);
  // ----------------------------------------
  // Clocking shared by all checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // ----------------------------------------
  // Register and interrupt checks
  // ----------------------------------------
  // Mask read shows only channel bits
  AST_IMR_UPPER: assert property (RD && ADDR == 8'h18 |=> RDATA[31:4] == 28'h0)
    else $error("mask read has upper bits");
  // Disable write clears the mask bit
  AST_IDR_BIT: assert property ((WR && ADDR == 8'h14 && WDATA[0] && !IRQ_EN_SET[0]) ##1
    (RD && ADDR == 8'h18 && !IRQ_EN_SET[0]) |=> !RDATA[0])
    else $error("disabled channel still in mask");
  // All disabled keeps the interrupt low
  AST_IRQ_OFF: assert property ((WR && ADDR == 8'h14 && WDATA[3:0] == 4'hF &&
    IRQ_EN_SET == 4'h0) ##1 (IRQ_EN_SET == 4'h0) [*2] |-> !IRQ)
    else $error("interrupt high with all disabled");
  // Duty, period, counter, update keep 16 bits
  AST_DATA_HIGH: assert property (RD && ADDR[7] && ADDR[4:2] != 3'h0 |=>
    RDATA[31:16] == 16'h0)
    else $error("channel word has upper bits");
  // Mode read has no stray bits
  AST_MODE_RSVD: assert property (RD && ADDR[7] && ADDR[4:0] == 5'h00 |=>
    RDATA[31:11] == 21'h0 && RDATA[7:4] == 4'h0)
    else $error("mode read has stray bits");
  // Mode fields read back as written
  AST_MODE_BACK: assert property ((WR && ADDR[7] && ADDR[4:0] == 5'h00) ##1
    (RD && ADDR == $past(ADDR)) |=> RDATA[10:0] == {$past(WDATA[10:8], 2), 4'h0,
    $past(WDATA[3:0], 2)})
    else $error("mode readback wrong");
  // Duty and period read back in 16 bits
  AST_DATA_BACK: assert property ((WR && ADDR[7] && (ADDR[4:0] == 5'h04 ||
    ADDR[4:0] == 5'h08)) ##1 (RD && ADDR == $past(ADDR)) |=>
    RDATA == {16'h0, $past(WDATA[15:0], 2)})
    else $error("duty or period readback wrong");
  // Enable pulse restarts the counter
  AST_CNT_CLEAR: assert property (CH_START[0] ##1 (RD && ADDR == 8'h8C) |=>
    RDATA[15:0] == 16'h0000)
    else $error("counter not cleared on enable");

  // Main scenarios reached
  COV_ISR: cover property (RD && ADDR == 8'h1C ##1 RDATA[0]);
  COV_IRQ: cover property ($rose(IRQ));
  COV_OUT: cover property ($fell(PWM_OUT[0]));
endmodule

bind pwmc_top pwmc_monitor u_mon (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CH_ENABLE(CH_ENABLE), .CH_START(CH_START),
  .CLK_A_TICK(CLK_A_TICK), .CLK_B_TICK(CLK_B_TICK), .IRQ_EN_SET(IRQ_EN_SET),
  .PWM_OUT(PWM_OUT), .IRQ(IRQ));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the four-channel modulator
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Design ports and bench state
  // ----------------------------------------
  logic        CLK_SYS;    // Master clock
  logic        RST;
  logic [7:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR;
  logic        RD;
  logic [31:0] RDATA;
  logic [3:0]  CH_ENABLE;  // Only channel 0 runs
  logic [3:0]  CH_START;
  logic        CLK_A_TICK; // Every 3 cycles
  logic        CLK_B_TICK; // Every 5 cycles
  logic [3:0]  IRQ_EN_SET;
  logic [3:0]  PWM_OUT;
  logic        IRQ;
  int          mismatches;
  int          checked;
  int          div_cnt;    // Divided clock phase
  int          n;          // Measured period
  logic [31:0] v;          // Read word
  logic [31:0] w;          // Random word
  logic [7:0]  a;
  logic [3:0]  code;
  logic        p;          // Start level

  pwmc_top DUT (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CH_ENABLE(CH_ENABLE), .CH_START(CH_START),
    .CLK_A_TICK(CLK_A_TICK), .CLK_B_TICK(CLK_B_TICK), .IRQ_EN_SET(IRQ_EN_SET),
    .PWM_OUT(PWM_OUT), .IRQ(IRQ));

  // Clock, 25 ns period
  initial
  begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  // Divided clock enables
  always @(posedge CLK_SYS)
  begin
    div_cnt <= (div_cnt + 1) % 15;
    CLK_A_TICK <= (div_cnt % 3) == 0;
    CLK_B_TICK <= (div_cnt % 5) == 0;
  end

  // ----------------------------------------
  // Bus, compare and wait tasks
  // ----------------------------------------
  // One cycle of all strobes
  task automatic drv(input logic wr_s, rd_s, input logic [7:0] ad, input logic [31:0] d,
    input logic [3:0] st, en);
    @(posedge CLK_SYS);
    WR <= wr_s;
    RD <= rd_s;
    ADDR <= ad;
    WDATA <= d;
    CH_START <= st;
    IRQ_EN_SET <= en;
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    drv(1'b1, 1'b0, ad, d, 4'h0, 4'h0);
  endtask
  // Data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    drv(1'b0, 1'b1, ad, 32'h0, 4'h0, 4'h0);
    drv(1'b0, 1'b0, ad, 32'h0, 4'h0, 4'h0);
    #1 d = RDATA;
  endtask
  task automatic idle(input int k);
    repeat (k) drv(1'b0, 1'b0, 8'h00, 32'h0, 4'h0, 4'h0);
  endtask
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e)
      $display("Error at %0t: got %h expected %h", $time, g, e);
    if (g !== e)
      mismatches++;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    rd(ad, v);
    chk(v, e);
  endtask
  // Bounded wait for a level on channel 0
  task automatic wl(input logic lv, inout int c);
    int t;
    for (t = 0; t < 4000 && PWM_OUT[0] !== lv; t++)
      idle(1);
    if (t == 4000)
      finish_test(1);
    c += t;
  endtask
  task automatic finish_test(input int f);
    mismatches += f;
    $display("Checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Expected period in master cycles
  function automatic int exp_per(input logic [3:0] c, input logic ctr, input int per);
    int dv;
    dv = (c == 4'hB) ? 3 : (c == 4'hC) ? 5 : (1 << c);
    return dv * per * (ctr ? 2 : 1);
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    RST = 1'b1;
    {WR, RD, ADDR, WDATA, CH_START, IRQ_EN_SET} = '0;
    CH_ENABLE = 4'h1;
    void'($urandom(32'h0b0b61aa));
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 16; i++)
      rc(8'h80 + 8'((i / 4) * 32 + (i % 4) * 4), 32'h0);
    rc(8'h18, 32'h0);
    $display("Test reset done");
    // Random fields on idle channels
    repeat (24)
    begin
      a = 8'h80 + 8'(($urandom % 3 + 1) * 32);
      w = $urandom;
      wr(a, w);
      rc(a, {21'h0, w[10:8], 4'h0, w[3:0]});
      a = a + 8'(($urandom % 2 + 1) * 4);
      w = $urandom;
      wr(a, w);
      rc(a, {16'h0, w[15:0]});
    end
    wr(8'hAC, w);
    rc(8'hAC, 32'h0);
    wr(8'h40, w);
    rc(8'h40, 32'h0);
    $display("Test fields done");
    // Mask set, disable, no effect of zero
    drv(1'b0, 1'b0, 8'h00, 32'h0, 4'h0, 4'hF);
    rc(8'h18, 32'h0000000F);
    wr(8'h14, 32'h5);
    rc(8'h18, 32'h0000000A);
    wr(8'h14, 32'h0);
    rc(8'h18, 32'h0000000A);
    wr(8'h14, 32'hF);
    idle(3);
    chk({31'h0, IRQ}, 32'h0);
    wr(8'h10, 32'h6);
    rc(8'h18, 32'h00000006);
    $display("Test mask done");
    // Period for codes 0-3 and clocks A, B, in both alignments
    for (int i = 0; i < 6; i++)
      for (int ct = 0; ct < 2; ct++)
      begin
        code = (i < 4) ? 4'(i) : 4'(i + 7);
        p = 1'($urandom);
        wr(8'h88, 32'h3);
        wr(8'h84, 32'h1);
        wr(8'h80, {22'h0, p, ct[0], 4'h0, code});
        drv(1'b0, 1'b0, 8'h00, 32'h0, 4'h1, 4'h0);
        // Let the restart reach the pin, then lock onto a real edge
        idle(3);
        wl(p, n);
        wl(~p, n);
        n = 0;
        wl(p, n);
        wl(~p, n);
        chk(32'(n), 32'(exp_per(code, ct[0], 3)));
      end
    $display("Test period done");
    // Status flag, interrupt and read clear
    drv(1'b0, 1'b0, 8'h00, 32'h0, 4'h0, 4'h1);
    idle(40);
    chk({31'h0, IRQ}, 32'h1);
    rd(8'h1C, v);
    chk(v & 32'h1, 32'h1);
    wr(8'h80, 32'h0000000D);
    rd(8'h1C, v);
    idle(2);
    rc(8'h1C, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    $display("Test status done");
    // Start level and restart of a held counter
    for (int k = 0; k < 2; k++)
    begin
      p = k[0];
      wr(8'h88, 32'h000000C8);
      wr(8'h80, {22'h0, p, 9'h0});
      idle(50);
      wr(8'h80, {22'h0, p, 5'h0, 4'hD});
      rd(8'h8C, w);
      rc(8'h8C, w);
      drv(1'b0, 1'b0, 8'h00, 32'h0, 4'h1, 4'h0);
      rc(8'h8C, 32'h0);
      idle(3);
      chk({31'h0, PWM_OUT[0]}, {31'h0, p});
    end
    $display("Test polarity done");
    // Buffered update of duty, then period
    wr(8'h90, 32'h2);
    rc(8'h84, 32'h1);
    wr(8'h80, 32'h0);
    idle(210);
    rc(8'h84, 32'h2);
    wr(8'h80, 32'h0000040D);
    wr(8'h90, 32'hFFFF0007);
    rc(8'h88, 32'h000000C8);
    wr(8'h80, 32'h00000400);
    idle(210);
    rc(8'h88, 32'h7);
    $display("Test update done");
    finish_test(0);
  end
endmodule
